//--- audio_sync_pkg.sv
package audio_sync_pkg;

    // register indices; each register is one aligned word at four times
    // its index, so the bus decodes haddr[ADDR_IDX_HI:ADDR_IDX_LO]
    localparam logic [7:0] GAIN_LOOP_SETUP_ADDR = 8'h40;
    localparam logic [7:0] INPUT_BUFFER_SETUP_ADDR = 8'h41;
    localparam logic [7:0] SYNC_EFFECT_SETUP_ADDR = 8'h42;
    localparam logic [7:0] SOURCE_ROUTE_SELECT_ADDR = 8'h43;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int ADDR_IDX_LO = 2;
    localparam int ADDR_IDX_HI = 9;

    // writable bit masks; bit 5 of the effect register is not kept
    localparam logic [7:0] GAIN_LOOP_MASK = 8'h7F;
    localparam logic [7:0] INPUT_BUFFER_MASK = 8'hFF;
    localparam logic [7:0] SYNC_EFFECT_MASK = 8'hDF;
    localparam logic [7:0] SOURCE_ROUTE_MASK = 8'h0F;

    // field positions
    localparam int GL_UP_LEVEL = 6;
    localparam int GL_DOWN_LEVEL = 5;
    localparam int GL_DN_DECAY_HI = 4;
    localparam int GL_DN_DECAY_LO = 3;
    localparam int GL_UP_DECAY_HI = 2;
    localparam int GL_UP_DECAY_LO = 1;
    localparam int GL_ON = 0;
    localparam int IB_PRECHARGE_OFF = 7;
    localparam int IB_MANUAL = 6;
    localparam int IB_GAIN_HI = 5;
    localparam int IB_GAIN_LO = 1;
    localparam int IB_BUF_ON = 0;
    localparam int SE_PIN_SEL = 7;
    localparam int SE_PULLDOWN_OFF = 6;
    localparam int SE_DECAY_HI = 4;
    localparam int SE_DECAY_LO = 3;
    localparam int SE_MODE_HI = 2;
    localparam int SE_MODE_LO = 0;
    localparam int NUM_SOURCES = 4;

    // gain window of the loop around the programmed start value, in dB steps
    localparam logic [4:0] GAIN_SWING = 5'h03;
    localparam logic [4:0] GAIN_MAX = 5'h1F;

    typedef enum logic [2:0] {
        EFFECT_BAR = 3'h0,
        EFFECT_BAR_DIM = 3'h1,
        EFFECT_RUN = 3'h2,
        EFFECT_RUN_DIM = 3'h3,
        EFFECT_MIX = 3'h4,
        EFFECT_MIX_DIM = 3'h5,
        EFFECT_PAR_DIM = 3'h6,
        EFFECT_FORBIDDEN = 3'h7
    } effect_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b11
    } bus_phase_e;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
        logic [31:0] hwdata;
    } ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_s;

    typedef struct packed {
        logic up_level_raised;
        logic down_level_raised;
        logic [1:0] down_decay;
        logic [1:0] up_decay;
        logic loop_on;
        logic [4:0] gain_start;
        logic [4:0] gain_floor;
        logic [4:0] gain_ceiling;
        logic buffer_on;
        logic manual_precharge;
        logic precharge_active;
    } preamp_ctrl_s;

    typedef struct packed {
        logic pin_from_fourth_output;
        logic pulldown_on;
        logic [1:0] decay;
        effect_e effect;
        logic effect_illegal;
        logic [3:0] sound_route;
    } effect_ctrl_s;

    typedef struct packed {
        bus_phase_e phase;
        logic [7:0] addr;
        logic [7:0] gain_loop_setup;
        logic [7:0] input_buffer_setup;
        logic [7:0] sync_effect_setup;
        logic [7:0] source_route_select;
        logic [31:0] rdata;
    } regs_state_s;

endpackage : audio_sync_pkg

//--- audio_sync_control_regs.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module audio_sync_control_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register bus
    input wire audio_sync_pkg::ahb_req_s ahb_req,
    output audio_sync_pkg::ahb_rsp_s ahb_rsp,
    // per-source drive levels
    input wire logic [15:0] pattern_level,
    input wire logic [15:0] audio_level,
    output logic [15:0] source_level,
    // control to the analog path
    output audio_sync_pkg::preamp_ctrl_s preamp_ctrl,
    output audio_sync_pkg::effect_ctrl_s effect_ctrl
);
    import audio_sync_pkg::*;

    regs_state_s s_q;
    regs_state_s s_d;
    logic [7:0] wbyte;
    logic [4:0] gain_code;
    logic [3:0] route_eff;

    // one-cycle data phase keeps hreadyout high always; the bus never waits
    always_comb begin
        s_d = s_q;
        wbyte = ahb_req.hwdata[7:0];
        s_d.rdata = 32'h0000_0000;
        if (s_q.phase == BUS_WRITE) begin
            case (s_q.addr)
                GAIN_LOOP_SETUP_ADDR: begin
                    s_d.gain_loop_setup = wbyte & GAIN_LOOP_MASK;
                end
                INPUT_BUFFER_SETUP_ADDR: begin
                    s_d.input_buffer_setup = wbyte & INPUT_BUFFER_MASK;
                end
                SYNC_EFFECT_SETUP_ADDR: begin
                    s_d.sync_effect_setup = wbyte & SYNC_EFFECT_MASK;
                end
                SOURCE_ROUTE_SELECT_ADDR: begin
                    s_d.source_route_select = wbyte & SOURCE_ROUTE_MASK;
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        s_d.phase = BUS_IDLE;
        if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
            s_d.phase = ahb_req.hwrite ? BUS_WRITE : BUS_READ;
            // misaligned or out-of-range addresses alias to an unmapped index
            s_d.addr = 8'h00;
            if (ahb_req.haddr[ADDR_IDX_LO-1:0] == '0 &&
                ahb_req.haddr[31:ADDR_IDX_HI+1] == '0) begin
                s_d.addr = ahb_req.haddr[ADDR_IDX_HI:ADDR_IDX_LO];
            end
            if (!ahb_req.hwrite) begin
                case (s_d.addr)
                    GAIN_LOOP_SETUP_ADDR:
                        s_d.rdata = {24'h00_0000, s_d.gain_loop_setup};
                    INPUT_BUFFER_SETUP_ADDR:
                        s_d.rdata = {24'h00_0000, s_d.input_buffer_setup};
                    SYNC_EFFECT_SETUP_ADDR:
                        s_d.rdata = {24'h00_0000, s_d.sync_effect_setup};
                    SOURCE_ROUTE_SELECT_ADDR:
                        s_d.rdata = {24'h00_0000, s_d.source_route_select};
                    default:
                        s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{phase: BUS_IDLE, addr: 8'h00,
                     gain_loop_setup: REG_RESET,
                     input_buffer_setup: REG_RESET,
                     sync_effect_setup: REG_RESET,
                     source_route_select: REG_RESET,
                     rdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    // one driver for the whole response keeps the port a single variable
    assign ahb_rsp = '{hrdata: s_q.rdata, hreadyout: 1'b1, hresp: 1'b0};

    // gain window for the loop; clamped at the ends of the code range
    assign gain_code = s_q.input_buffer_setup[IB_GAIN_HI:IB_GAIN_LO];

    always_comb begin
        preamp_ctrl.up_level_raised = s_q.gain_loop_setup[GL_UP_LEVEL];
        preamp_ctrl.down_level_raised =
            s_q.gain_loop_setup[GL_DOWN_LEVEL];
        preamp_ctrl.down_decay =
            s_q.gain_loop_setup[GL_DN_DECAY_HI:GL_DN_DECAY_LO];
        preamp_ctrl.up_decay =
            s_q.gain_loop_setup[GL_UP_DECAY_HI:GL_UP_DECAY_LO];
        preamp_ctrl.loop_on = s_q.gain_loop_setup[GL_ON];
        preamp_ctrl.gain_start = gain_code;
        preamp_ctrl.gain_floor = gain_code;
        preamp_ctrl.gain_ceiling = gain_code;
        if (s_q.gain_loop_setup[GL_ON]) begin
            preamp_ctrl.gain_floor = (gain_code > GAIN_SWING) ?
                gain_code - GAIN_SWING : 5'h00;
            preamp_ctrl.gain_ceiling = (gain_code < GAIN_MAX - GAIN_SWING) ?
                gain_code + GAIN_SWING : GAIN_MAX;
        end
        preamp_ctrl.buffer_on = s_q.input_buffer_setup[IB_BUF_ON];
        preamp_ctrl.manual_precharge =
            s_q.input_buffer_setup[IB_MANUAL];
        // automatic mode ignores the disable bit
        preamp_ctrl.precharge_active = !s_q.input_buffer_setup[IB_MANUAL] ||
            !s_q.input_buffer_setup[IB_PRECHARGE_OFF];
    end

    always_comb begin
        effect_ctrl.pin_from_fourth_output =
            s_q.sync_effect_setup[SE_PIN_SEL];
        effect_ctrl.pulldown_on = !s_q.sync_effect_setup[SE_PULLDOWN_OFF] &&
            !s_q.input_buffer_setup[IB_BUF_ON];
        effect_ctrl.decay =
            s_q.sync_effect_setup[SE_DECAY_HI:SE_DECAY_LO];
        effect_ctrl.effect =
            effect_e'(s_q.sync_effect_setup[SE_MODE_HI:SE_MODE_LO]);
        effect_ctrl.effect_illegal =
            (effect_ctrl.effect == EFFECT_FORBIDDEN);
        effect_ctrl.sound_route = route_eff;
    end

    // colour-mix effects never claim the fourth source
    always_comb begin
        route_eff = s_q.source_route_select[NUM_SOURCES-1:0];
        if (effect_ctrl.effect == EFFECT_MIX ||
            effect_ctrl.effect == EFFECT_MIX_DIM) begin
            route_eff[NUM_SOURCES-1] = 1'b0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_SOURCES; i++) begin : g_src
            assign source_level[i*4 +: 4] = route_eff[i] ?
                audio_level[i*4 +: 4] : pattern_level[i*4 +: 4];
        end
    endgenerate

endmodule : audio_sync_control_regs

`default_nettype wire

//--- audio_sync_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module audio_sync_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register bus
    input wire audio_sync_pkg::ahb_req_s ahb_req,
    input wire audio_sync_pkg::ahb_rsp_s ahb_rsp,
    // levels and control
    input wire logic [15:0] pattern_level,
    input wire logic [15:0] audio_level,
    input wire logic [15:0] source_level,
    input wire audio_sync_pkg::preamp_ctrl_s preamp_ctrl,
    input wire audio_sync_pkg::effect_ctrl_s effect_ctrl
);
    import audio_sync_pkg::*;
    logic wr_q;
    logic [31:0] adr_q;
    logic wl;
    logic wb;
    logic ws;
    logic rd_q;
    // data phase of a write, so hwdata is valid while these are high
    assign wl = wr_q && adr_q == {22'h0, GAIN_LOOP_SETUP_ADDR, 2'b00};
    assign wb = wr_q && adr_q == {22'h0, INPUT_BUFFER_SETUP_ADDR, 2'b00};
    assign ws = wr_q && adr_q == {22'h0, SYNC_EFFECT_SETUP_ADDR, 2'b00};
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= '0;
        end else begin
            wr_q <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]
                && ahb_req.hwrite;
            rd_q <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]
                && !ahb_req.hwrite;
            adr_q <= ahb_req.haddr;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_gain_wr; wl; endsequence
    property p_up; s_gain_wr |=>
        preamp_ctrl.up_level_raised == $past(ahb_req.hwdata[6]); endproperty
    a_up: assert property (p_up) else $error("up level wrong");
    property p_dn; s_gain_wr |=>
        preamp_ctrl.down_decay == $past(ahb_req.hwdata[4:3]); endproperty
    a_dn: assert property (p_dn) else $error("down decay wrong");
    property p_on; s_gain_wr |=>
        preamp_ctrl.loop_on == $past(ahb_req.hwdata[0]); endproperty
    a_on: assert property (p_on) else $error("loop enable wrong");
    property p_gain; wb |=>
        preamp_ctrl.gain_start == $past(ahb_req.hwdata[5:1]); endproperty
    a_gain: assert property (p_gain) else $error("gain wrong");
    property p_pd; ws && ahb_req.hwdata[6] |=>
        !effect_ctrl.pulldown_on; endproperty
    a_pd: assert property (p_pd) else $error("pulldown on");
    property p_mix; effect_ctrl.effect inside {EFFECT_MIX, EFFECT_MIX_DIM}
        |-> !effect_ctrl.sound_route[3]; endproperty
    a_mix: assert property (p_mix) else $error("fourth source used");
    property p_mux; source_level[3:0] == (effect_ctrl.sound_route[0] ?
        audio_level[3:0] : pattern_level[3:0]); endproperty
    a_mux: assert property (p_mux) else $error("source1 level");
    property p_swing; preamp_ctrl.loop_on |->
        preamp_ctrl.gain_ceiling - preamp_ctrl.gain_start <= 5'h03 &&
        preamp_ctrl.gain_start - preamp_ctrl.gain_floor <= 5'h03; endproperty
    a_swing: assert property (p_swing) else $error("gain window");
    // read data stands only in a read data phase; the bus never waits
    property p_rdata; !rd_q |-> ahb_rsp.hrdata == 32'h0 &&
        ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
    a_rdata: assert property (p_rdata) else $error("bus response");
endmodule : audio_sync_asserts

`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import audio_sync_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    ahb_req_s drv = '0;
    ahb_req_s req;
    ahb_rsp_s rsp;
    ahb_rsp_s smp;
    logic [15:0] pat = 16'h1234;
    logic [15:0] aud = 16'hABCD;
    logic [15:0] lvl;
    preamp_ctrl_s pre;
    effect_ctrl_s eff;
    logic [31:0] q;
    logic [7:0] v;
    logic [2:0] c;
    logic [3:0] rt;
    logic [7:0] msk [5] = '{GAIN_LOOP_MASK, INPUT_BUFFER_MASK,
        SYNC_EFFECT_MASK, SOURCE_ROUTE_MASK, 8'h00};
    int err_total = 0;
    int n_tests = 0;
    always #50 ref_clk = ~ref_clk;
    always_comb begin
        req = drv;
        req.hready = rsp.hreadyout;
    end
    // sampled at the edge so the bench never races the design's updates
    always @(posedge ref_clk) smp <= rsp;
    audio_sync_control_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .ahb_req(req), .ahb_rsp(rsp), .pattern_level(pat),
        .audio_level(aud), .source_level(lvl), .preamp_ctrl(pre),
        .effect_ctrl(eff));
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // one aligned word per register: byte address is four times (GAIN_LOOP_SETUP_ADDR + index)
    function automatic logic [31:0] reg_addr(input int idx);
        return {22'h00_0000, GAIN_LOOP_SETUP_ADDR + 8'(idx), 2'b00};
    endfunction : reg_addr
    task automatic wait_rdy;
        do begin
            @(posedge ref_clk);
            #1;
        end while (smp.hreadyout !== 1'b1);
    endtask : wait_rdy
    task automatic bus(input logic [31:0] a, input logic w,
        input logic [7:0] d);
        drv.haddr <= a;
        drv.hwrite <= w;
        drv.htrans <= 2'b10;
        drv.hsel <= 1'b1;
        drv.hsize <= 3'h2;
        wait_rdy();
        drv.htrans <= 2'b00;
        drv.hwdata <= {24'h0, d};
        wait_rdy();
        q = smp.hrdata;
        cmp("hresp", 32'h0, smp.hresp);
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        cmp("readback", e, q);
    endtask : rd
    task automatic pchk(input logic [7:0] d, input logic [17:0] e);
        wr(reg_addr(1), d);
        cmp("preamp", e, {pre.gain_start, pre.gain_floor, pre.gain_ceiling,
            pre.buffer_on, pre.manual_precharge, pre.precharge_active});
    endtask : pchk
    task automatic summarize;
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1;
        cmp("reset", {16'h1234, 6'h03}, {lvl, eff.sound_route,
            eff.pulldown_on, pre.precharge_active});
        for (int i = 0; i < 4; i++) rd(reg_addr(i), 32'h0);
        // index 4 is the unmapped word just above the bank
        for (int i = 0; i < 5; i++) begin
            wr(reg_addr(i), 8'hFF);
            rd(reg_addr(i), {24'h0, msk[i]});
        end
        for (int k = 0; k < 4; k++) begin
            c = 3'(k);
            v = {1'b0, c[0], c[1], c[1:0], c[1:0], c[0]};
            wr(reg_addr(0), v);
            cmp("agc", v, {pre.up_level_raised, pre.down_level_raised,
                pre.down_decay, pre.up_decay, pre.loop_on});
        end
        pchk(8'h3E, {5'h1F, 5'h1C, 5'h1F, 3'b001});
        pchk(8'hC1, {5'h00, 5'h00, 5'h03, 3'b110});
        pchk(8'h41, {5'h00, 5'h00, 5'h03, 3'b111});
        pchk(8'h80, {5'h00, 5'h00, 5'h03, 3'b001});
        pchk(8'h0A, {5'h05, 5'h02, 5'h08, 3'b001});
        wr(reg_addr(0), 8'h00);
        pchk(8'h0A, {5'h05, 5'h05, 5'h05, 3'b001});
        for (int m = 0; m < 8; m++) begin
            c = 3'(m);
            wr(reg_addr(2), {c[0], 1'b0, 1'b1, c[1:0], c});
            rt = (c[2:1] == 2'b10) ? 4'h7 : 4'hF;
            cmp("effect", {c[0], 1'b1, c[1:0], c, c == 3'h7, rt},
                eff);
            cmp("level", rt[3] ? 16'hABCD : 16'h1BCD, lvl);
        end
        wr(reg_addr(3), 8'hF5);
        rd(reg_addr(3), 32'h5);
        cmp("level", 16'h1B3D, lvl);
        wr(reg_addr(2), 8'h40);
        cmp("pulldown", 32'h0, eff.pulldown_on);
        wr(reg_addr(2), 8'h00);
        wr(reg_addr(1), 8'h01);
        cmp("pulldown", 32'h0, eff.pulldown_on);
        // a reset in mid-run must bring every field back to zero
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1;
        cmp("reset", {16'h1234, 6'h03}, {lvl, eff.sound_route,
            eff.pulldown_on, pre.precharge_active});
        for (int i = 0; i < 4; i++) rd(reg_addr(i), 32'h0);
        summarize();
    end
endmodule : testbench

bind audio_sync_control_regs audio_sync_asserts u_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .pattern_level(pattern_level), .audio_level(audio_level),
    .source_level(source_level), .preamp_ctrl(preamp_ctrl),
    .effect_ctrl(effect_ctrl));

`default_nettype wire
